// ==== logic/sram_tap_pkg.sv ====
/*
 * Constants and types of the boundary-scan test port: controller states,
 * instruction codes, scan lengths, identification word and register map.
 * Assumes one core clock domain that samples the test pins.
 */
package sram_tap_pkg;

	typedef enum logic [3:0] {
		TLR    = 4'h0,
		IDLE   = 4'h1,
		SEL_DR = 4'h2,
		CAP_DR = 4'h3,
		SH_DR  = 4'h4,
		EX1_DR = 4'h5,
		PA_DR  = 4'h6,
		EX2_DR = 4'h7,
		UPD_DR = 4'h8,
		SEL_IR = 4'h9,
		CAP_IR = 4'ha,
		SH_IR  = 4'hb,
		EX1_IR = 4'hc,
		PA_IR  = 4'hd,
		EX2_IR = 4'he,
		UPD_IR = 4'hf
	} tap_e;

	typedef enum logic [1:0] {
		PATH_BSR = 2'h0,
		PATH_ID  = 2'h1,
		PATH_BYP = 2'h2
	} path_e;

	localparam int         IR_W        = 3;
	localparam int         ID_W        = 32;
	localparam int         BSR_W       = 89;
	localparam int         TRI_CELL    = 88;
	localparam logic [2:0] IR_EXTEST   = 3'h0;
	localparam logic [2:0] IR_IDCODE   = 3'h1;
	localparam logic [2:0] IR_SAMPLEZ  = 3'h2;
	localparam logic [2:0] IR_PRELOAD  = 3'h4;
	localparam logic [2:0] IR_BYPASS   = 3'h7;
	localparam logic [2:0] IR_CAPTURE  = 3'h1;
	localparam logic [2:0] RESET_EDGES = 3'h5;

	// Part and vendor fields are arbitrary values.
	localparam logic [2:0]  ID_REV    = 3'h0;
	localparam logic [16:0] ID_PART   = 17'h00a5a;
	localparam logic [10:0] ID_VENDOR = 11'h2a5;
	localparam logic [31:0] ID_WORD   = {ID_REV, ID_PART, ID_VENDOR, 1'b1};

	localparam int         AXI_AW     = 4;
	localparam logic [3:0] OFS_CTRL   = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_ID     = 4'h8;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_DEC   = 2'h3;
	localparam int         ST_IR_LSB  = 4;
	localparam int         ST_XT_BIT  = 8;
	localparam int         ST_QOE_BIT = 9;
	localparam logic       CTRL_RST   = 1'b1;

endpackage

// ==== logic/sram_tap.sv ====
/*
 * Boundary-scan test port of a synchronous SRAM with an AXI4-Lite window.
 * Assumes the test pins come from an unrelated tester clock and are
 * sampled by CORE_CLK, which must run well above the test clock.
 * The I/O ring values arrive already in the CORE_CLK domain.
 */
`timescale 1ns/1ps

// Contract
// - Sample on test-clock rise, drive on fall.
// - Mode and data inputs default high.
// - Shift in at MSB, out at LSB.
// - Data output driven only while shifting.
// - Five high mode edges reach reset state.
// - Port reset leaves memory operation alone.
// - Power-up resets port, output floats.
// - Instruction selects exactly one scan path.
// - Three-bit instruction, identify after reset.
// - Instruction capture loads pattern 01.
// - New instruction acts only at update.
// - Bypass bit captures low.
// - Boundary register captures ring, then shifts.
// - Identify captures fixed 32-bit word.
// - Float-sample floats output bus until update.
// - Sample snapshots pins, memory undisturbed.
// - Preload shifts in, latches at update.
// - External test drives latched values out.
// - Cell 89 gates outputs under external test.
// - Cell 89 latch preset high at reset.
// - Codes 000,001,010,100 as documented.
// - ID: revision, vendor, presence bit.
module sram_tap
	import sram_tap_pkg::*;
(
	// Clock and reset.
	input  wire logic                CORE_CLK,
	input  wire logic                RST_B,
	// Test pins.
	input  wire logic                TCK,
	input  wire logic                TMS,
	input  wire logic                TDI,
	output logic                     TDO,
	output logic                     TDO_OE,
	// I/O ring.
	input  wire logic [BSR_W-1:0]    RING_IN,
	output logic      [BSR_W-1:0]    RING_OUT,
	output logic                     RING_DRIVE,
	output logic                     Q_OE,
	// AXI4-Lite slave.
	input  wire logic                AWVALID,
	output logic                     AWREADY,
	input  wire logic [AXI_AW-1:0]   AWADDR,
	input  wire logic                WVALID,
	output logic                     WREADY,
	input  wire logic [31:0]         WDATA,
	input  wire logic [3:0]          WSTRB,
	output logic                     BVALID,
	input  wire logic                BREADY,
	output logic      [1:0]          BRESP,
	input  wire logic                ARVALID,
	output logic                     ARREADY,
	input  wire logic [AXI_AW-1:0]   ARADDR,
	output logic                     RVALID,
	input  wire logic                RREADY,
	output logic      [31:0]         RDATA,
	output logic      [1:0]          RRESP
);

	typedef struct packed {
		logic [2:0]        tck_s;
		logic [1:0]        tms_s;
		logic [1:0]        tdi_s;
		tap_e              state;
		logic [IR_W-1:0]   ir;
		logic [IR_W-1:0]   ir_sh;
		logic              byp;
		logic [ID_W-1:0]   id_sh;
		logic [BSR_W-1:0]  bsr;
		logic [BSR_W-1:0]  latch;
		logic              tdo;
		logic              tdo_oe;
		logic              q_oe;
		logic              drive;
		logic              core_oe;
		logic              aw_got;
		logic              w_got;
		logic [AXI_AW-1:0] awaddr;
		logic [31:0]       wdata;
		logic              wstb0;
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [1:0]        rresp;
		logic [31:0]       rdata;
	} st_s;

	st_s q;
	st_s d;
	logic rise;
	logic fall;
	logic tms;
	logic tdi;
	logic [2:0] hi_cnt_q;

	function automatic tap_e tap_next(input tap_e s, input logic m);
		tap_e n;
		n = s;
		case (s)
			TLR:     n = m ? TLR : IDLE;
			IDLE:    n = m ? SEL_DR : IDLE;
			SEL_DR:  n = m ? SEL_IR : CAP_DR;
			CAP_DR:  n = m ? EX1_DR : SH_DR;
			SH_DR:   n = m ? EX1_DR : SH_DR;
			EX1_DR:  n = m ? UPD_DR : PA_DR;
			PA_DR:   n = m ? EX2_DR : PA_DR;
			EX2_DR:  n = m ? UPD_DR : SH_DR;
			UPD_DR:  n = m ? SEL_DR : IDLE;
			SEL_IR:  n = m ? TLR : CAP_IR;
			CAP_IR:  n = m ? EX1_IR : SH_IR;
			SH_IR:   n = m ? EX1_IR : SH_IR;
			EX1_IR:  n = m ? UPD_IR : PA_IR;
			PA_IR:   n = m ? EX2_IR : PA_IR;
			EX2_IR:  n = m ? UPD_IR : SH_IR;
			UPD_IR:  n = m ? SEL_DR : IDLE;
			default: n = TLR;
		endcase
		return n;
	endfunction

	// Reserved codes are unusable, so they fall back to the shortest path.
	function automatic path_e path_of(input logic [IR_W-1:0] i);
		path_e p;
		case (i)
			IR_EXTEST:  p = PATH_BSR;
			IR_SAMPLEZ: p = PATH_BSR;
			IR_PRELOAD: p = PATH_BSR;
			IR_IDCODE:  p = PATH_ID;
			default:    p = PATH_BYP;
		endcase
		return p;
	endfunction

	function automatic logic [1:0] resp_of(input logic [AXI_AW-1:0] a);
		logic [1:0] r;
		r = RESP_DEC;
		if (a == OFS_CTRL || a == OFS_STATUS || a == OFS_ID) begin
			r = RESP_OKAY;
		end
		return r;
	endfunction

	// Edges come from the second and third sampling stages only.
	assign rise = q.tck_s[1] & ~q.tck_s[2];
	assign fall = ~q.tck_s[1] & q.tck_s[2];
	assign tms  = q.tms_s[1];
	assign tdi  = q.tdi_s[1];

	always_comb begin
		d = q;
		d.tck_s = {q.tck_s[1:0], TCK};
		d.tms_s = {q.tms_s[0], TMS};
		d.tdi_s = {q.tdi_s[0], TDI};

		if (rise) begin
			d.state = tap_next(q.state, tms);
			case (q.state)
				CAP_IR: begin
					d.ir_sh = IR_CAPTURE;
				end
				SH_IR: begin
					d.ir_sh = {tdi, q.ir_sh[IR_W-1:1]};
				end
				UPD_IR: begin
					d.ir = q.ir_sh;
				end
				CAP_DR: begin
					case (path_of(q.ir))
						PATH_BSR: d.bsr = RING_IN;
						PATH_ID:  d.id_sh = ID_WORD;
						default:  d.byp = 1'b0;
					endcase
				end
				SH_DR: begin
					case (path_of(q.ir))
						PATH_BSR: d.bsr = {tdi, q.bsr[BSR_W-1:1]};
						PATH_ID:  d.id_sh = {tdi, q.id_sh[ID_W-1:1]};
						default:  d.byp = tdi;
					endcase
				end
				UPD_DR: begin
					if (path_of(q.ir) == PATH_BSR) begin
						d.latch = q.bsr;
					end
				end
				default: begin
				end
			endcase
		end

		// Entering the reset state restores identify and the tristate cell.
		if (d.state == TLR) begin
			d.ir = IR_IDCODE;
			d.latch[TRI_CELL] = 1'b1;
		end

		if (fall) begin
			d.tdo_oe = (q.state == SH_DR) || (q.state == SH_IR);
			if (q.state == SH_IR) begin
				d.tdo = q.ir_sh[0];
			end else begin
				case (path_of(q.ir))
					PATH_BSR: d.tdo = q.bsr[0];
					PATH_ID:  d.tdo = q.id_sh[0];
					default:  d.tdo = q.byp;
				endcase
			end
		end

		// The core enable is not touched by the test port reset.
		if (q.ir == IR_SAMPLEZ) begin
			d.q_oe = 1'b0;
		end else if (q.ir == IR_EXTEST) begin
			d.q_oe = q.latch[TRI_CELL];
		end else begin
			d.q_oe = q.core_oe;
		end
		d.drive = (q.ir == IR_EXTEST);

		if (q.bvalid && BREADY) begin
			d.bvalid = 1'b0;
		end
		if (AWVALID && q.awready) begin
			d.aw_got = 1'b1;
			d.awaddr = AWADDR;
		end
		if (WVALID && q.wready) begin
			d.w_got = 1'b1;
			d.wdata = WDATA;
			d.wstb0 = WSTRB[0];
		end
		if (d.aw_got && d.w_got && !d.bvalid) begin
			d.bvalid = 1'b1;
			d.bresp = resp_of(d.awaddr);
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			if (d.awaddr == OFS_CTRL && d.wstb0) begin
				d.core_oe = d.wdata[0];
			end
		end
		d.awready = ~d.aw_got;
		d.wready = ~d.w_got;

		if (q.rvalid && RREADY) begin
			d.rvalid = 1'b0;
		end
		if (ARVALID && q.arready) begin
			d.rvalid = 1'b1;
			d.rresp = resp_of(ARADDR);
			d.rdata = '0;
			case (ARADDR)
				OFS_CTRL: d.rdata[0] = q.core_oe;
				OFS_STATUS: begin
					d.rdata[3:0] = q.state;
					d.rdata[ST_IR_LSB +: IR_W] = q.ir;
					d.rdata[ST_XT_BIT] = q.drive;
					d.rdata[ST_QOE_BIT] = q.q_oe;
				end
				OFS_ID: d.rdata = ID_WORD;
				default: d.rdata = '0;
			endcase
		end
		d.arready = ~d.rvalid;
	end

	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			q <= '0;
			q.tms_s <= 2'h3;
			q.tdi_s <= 2'h3;
			q.state <= TLR;
			q.ir <= IR_IDCODE;
			q.latch[TRI_CELL] <= 1'b1;
			q.q_oe <= 1'b1;
			q.core_oe <= CTRL_RST;
			q.awready <= 1'b1;
			q.wready <= 1'b1;
			q.arready <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign TDO        = q.tdo;
	assign TDO_OE     = q.tdo_oe;
	assign RING_OUT   = q.latch;
	assign RING_DRIVE = q.drive;
	assign Q_OE       = q.q_oe;
	assign AWREADY    = q.awready;
	assign WREADY     = q.wready;
	assign BVALID     = q.bvalid;
	assign BRESP      = q.bresp;
	assign ARREADY    = q.arready;
	assign RVALID     = q.rvalid;
	assign RDATA      = q.rdata;
	assign RRESP      = q.rresp;

	// Counts consecutive test-clock rises seen with mode high.
	// It saturates, so a long high run cannot wrap back below five.
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			hi_cnt_q <= 3'h0;
		end else if (rise) begin
			if (!tms) begin
				hi_cnt_q <= 3'h0;
			end else if (hi_cnt_q != 3'h7) begin
				hi_cnt_q <= hi_cnt_q + 3'h1;
			end
		end
	end

	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RST_B);

	chk_state_on_rise: assert property (!rise |=> $stable(q.state))
		else $error("State moved without a test-clock rise.");
	chk_tdo_on_fall: assert property (!fall |=> $stable(TDO) && $stable(TDO_OE))
		else $error("Data output moved without a test-clock fall.");
	chk_tdo_float: assert property (fall |=> TDO_OE == ($past(q.state) inside {SH_DR, SH_IR}))
		else $error("Data output enable wrong after a fall.");
	chk_five_high: assert property (hi_cnt_q >= RESET_EDGES |-> q.state == TLR)
		else $error("Five high mode edges did not reset.");
	chk_reset_instr: assert property (q.state == TLR |-> q.ir == IR_IDCODE && q.latch[TRI_CELL])
		else $error("Reset state without identify or preset cell.");
	chk_capture_ir: assert property (rise && q.state == CAP_IR |=> q.ir_sh[1:0] == 2'b01)
		else $error("Instruction capture pattern wrong.");
	chk_ir_update: assert property (rise && q.state == UPD_IR |=> q.ir == $past(q.ir_sh))
		else $error("Instruction not taken at update.");
	chk_ir_hold: assert property (!(rise && q.state == UPD_IR) && !(q.state == TLR)
		##1 q.state != TLR |-> $stable(q.ir))
		else $error("Instruction changed outside update.");
	chk_bypass_low: assert property (rise && q.state == CAP_DR && path_of(q.ir) == PATH_BYP
		|=> !q.byp)
		else $error("Bypass bit not captured low.");
	chk_id_capture: assert property (rise && q.state == CAP_DR && q.ir == IR_IDCODE
		|=> q.id_sh == ID_WORD && q.id_sh[0])
		else $error("Identify word not captured.");
	chk_float_sample: assert property (q.ir == IR_SAMPLEZ |=> !Q_OE)
		else $error("Output bus not floated under float-sample.");
	chk_tri_cell: assert property (q.ir == IR_EXTEST |=> Q_OE == $past(q.latch[TRI_CELL]) && RING_DRIVE)
		else $error("Tristate cell does not control outputs.");
	chk_preload_latch: assert property (rise && q.state == UPD_DR && path_of(q.ir) == PATH_BSR
		|=> RING_OUT == $past(q.bsr))
		else $error("Preload pattern not latched.");
	chk_core_oe: assert property (q.ir != IR_SAMPLEZ && q.ir != IR_EXTEST |=> Q_OE == $past(q.core_oe))
		else $error("Core output enable not passed through.");
	chk_tdo_lsb: assert property (fall && q.state == SH_IR |=> TDO == $past(q.ir_sh[0]))
		else $error("Instruction shift does not leave at the low bit.");
	chk_ring_drive: assert property (q.ir != IR_EXTEST |=> !RING_DRIVE)
		else $error("Ring driven outside external test.");

	cov_id_shift: cover property (q.ir == IR_IDCODE && rise && q.state == SH_DR);
	cov_ir_update: cover property (rise && q.state == UPD_IR ##1 q.ir == IR_EXTEST);
	cov_extest_float: cover property (q.drive && !Q_OE);
	cov_tap_reset: cover property (hi_cnt_q == RESET_EDGES);

endmodule

// ==== testbench/tap_tester.sv ====
/*
 * Behavioural board-level tester for the scan port: makes the link clock and
 * walks the controller with mode and data bits.
 * Assumes TDO is resolved with its enable; the link clock stands low between frames.
 */
`timescale 1ns/1ps
module tap_tester (
	// Test pins.
	output logic      TCK,
	output logic      TMS,
	output logic      TDI,
	input  wire logic TDO,
	input  wire logic TDO_OE
);
	initial begin
		TCK = 1'b0;
		TMS = 1'b1;
		TDI = 1'b1;
	end
	// One 400 ns period; inputs move while the clock is low so the rise samples settled bits.
	// Every call starts on a core clock edge, so all pin moves use non-blocking assignment to avoid a race.
	task automatic step(input logic tms, input logic tdi, output logic tdo);
		TMS <= tms;
		TDI <= tdi;
		#200 TCK <= 1'b1;
		tdo = TDO_OE ? TDO : 1'bz;
		#200 TCK <= 1'b0;
	endtask
	task automatic reset5();
		logic b;
		repeat (5) step(1'b1, 1'b1, b);
		step(1'b0, 1'b1, b);
	endtask
	// Bit 0 leaves first, the last bit leaves with mode high.
	task automatic scan(input int n, input logic [127:0] din, output logic [127:0] dout);
		logic b;
		dout = '0;
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], b);
			dout[i] = b;
		end
	endtask
	task automatic ir(input logic [2:0] code, output logic [2:0] cap);
		logic b;
		logic [127:0] t;
		step(1'b1, 1'b1, b);
		step(1'b1, 1'b1, b);
		step(1'b0, 1'b1, b);
		step(1'b0, 1'b1, b);
		scan(3, {125'h0, code}, t);
		step(1'b1, 1'b1, b);
		step(1'b0, 1'b1, b);
		cap = t[2:0];
	endtask
	task automatic dr(input logic [127:0] din, output logic [127:0] dout);
		logic b;
		step(1'b1, 1'b1, b);
		step(1'b0, 1'b1, b);
		step(1'b0, 1'b1, b);
		scan(128, din, dout);
		step(1'b1, 1'b1, b);
		step(1'b0, 1'b1, b);
	endtask
endmodule

// ==== testbench/sram_boundary_scan_tap_tb.sv ====
/*
 * Self-checking bench of the scan port: every defined instruction code is exercised, a scan
 * is compared with a bit model, and the register window is read back.
 * Assumes the tester model drives the test pins and this module the AXI side.
 */
`timescale 1ns/1ps
module sram_boundary_scan_tap_tb;
	import sram_tap_pkg::*;
	logic             clk, rst_b, tdo, tdo_oe, drv, q_oe;
	wire logic        tck, tms, tdi;
	logic [BSR_W-1:0] ring_in, ring_out, exp_ring;
	logic             awv, awr, wv, wr_, bv, br, arv, arr, rv, rr;
	logic [3:0]       awa, ara, wstrb;
	logic [31:0]      wd, rd_, rdat;
	logic [1:0]       bresp, rresp, resp;
	logic [127:0]     din, dout, expv;
	logic [95:0]      r96;
	logic [2:0]       cap, code;
	// Only defined codes are loaded; the first pass runs on the identify code left by reset.
	logic [2:0]       codes [8] = '{3'h1, 3'h0, 3'h2, 3'h4, 3'h7, 3'h0, 3'h4, 3'h2};
	int               num_errors, num_checks, len;

	tap_tester tester (.TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe));
	sram_tap i_dut (.CORE_CLK(clk), .RST_B(rst_b), .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo),
		.TDO_OE(tdo_oe), .RING_IN(ring_in), .RING_OUT(ring_out), .RING_DRIVE(drv), .Q_OE(q_oe),
		.AWVALID(awv), .AWREADY(awr), .AWADDR(awa), .WVALID(wv), .WREADY(wr_), .WDATA(wd),
		.WSTRB(wstrb), .BVALID(bv), .BREADY(br), .BRESP(bresp), .ARVALID(arv), .ARREADY(arr),
		.ARADDR(ara), .RVALID(rv), .RREADY(rr), .RDATA(rdat), .RRESP(rresp));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Both channels are offered together; each is dropped at its own handshake.
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		{awv, wv, br, awa, wd, wstrb} <= {3'b111, a, d, 4'hf};
		for (n = 0; n < 50 && !bv; n++) begin
			@(posedge clk);
			if (awv && awr) awv <= 1'b0;
			if (wv && wr_) wv <= 1'b0;
		end
		if (n == 50) begin
			num_errors++;
			wrap_up();
		end
		resp = bresp;
		br <= 1'b0;
	endtask
	task automatic axi_rd(input logic [3:0] a);
		int n;
		@(posedge clk);
		{arv, rr, ara} <= {2'b11, a};
		for (n = 0; n < 50 && !rv; n++) begin
			@(posedge clk);
			if (arv && arr) arv <= 1'b0;
		end
		if (n == 50) begin
			num_errors++;
			wrap_up();
		end
		{rd_, resp} = {rdat, rresp};
		rr <= 1'b0;
	endtask

	initial begin
		{rst_b, awv, wv, br, arv, rr, awa, ara, wd, wstrb, ring_in} = '0;
		void'($urandom(32'h8e7b));
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		exp_ring = '0;
		exp_ring[TRI_CELL] = 1'b1;
		chk(tdo_oe, 1'b0);
		chk(ring_out, exp_ring);
		chk({drv, q_oe}, 2'b01);
		axi_rd(OFS_ID);
		chk({resp, rd_}, {RESP_OKAY, ID_WORD});
		tester.reset5();
		for (int k = 0; k < 8; k++) begin
			code = codes[k];
			if (k > 0) tester.ir(code, cap);
			if (k > 0) chk(cap, 3'b001);
			r96 = {$urandom, $urandom, $urandom};
			@(posedge clk);
			ring_in <= r96[BSR_W-1:0];
			din = {$urandom, $urandom, $urandom, $urandom};
			@(posedge clk);
			case (code)
				IR_EXTEST, IR_SAMPLEZ, IR_PRELOAD: begin
					len = BSR_W;
					expv = {39'h0, ring_in};
				end
				IR_IDCODE: begin
					len = ID_W;
					expv = {96'h0, ID_WORD};
				end
				default: begin
					len = 1;
					expv = '0;
				end
			endcase
			tester.dr(din, dout);
			chk(dout, (din << len) | expv);
			if (len == BSR_W) exp_ring = din[127:39];
			chk(ring_out, exp_ring);
			chk(drv, code == IR_EXTEST);
			chk(q_oe, code == IR_SAMPLEZ ? 1'b0 : code == IR_EXTEST ? exp_ring[TRI_CELL] : 1'b1);
			chk(tdo_oe, 1'b0);
			axi_rd(OFS_STATUS);
			chk({rd_[8], rd_[6:4], rd_[3:0]}, {code == IR_EXTEST, code, 4'h1});
		end
		axi_wr(OFS_CTRL, 32'h0);
		chk(resp, RESP_OKAY);
		tester.reset5();
		axi_rd(OFS_STATUS);
		chk(rd_[6:4], IR_IDCODE);
		axi_rd(OFS_CTRL);
		chk({q_oe, rd_[0]}, 2'b00);
		chk(ring_out[TRI_CELL], 1'b1);
		axi_rd(4'hc);
		chk({resp, rd_}, {RESP_DEC, 32'h0});
		axi_wr(4'hc, 32'h1);
		chk(resp, RESP_DEC);
		wrap_up();
	end
endmodule
